// File: sgd_pkg.sv
package sgd_pkg;

  // Register word offsets from the board base address, channel 0
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] MAIN_CUR_ADDR_OFS = 8'h00;
  localparam logic [7:0] MAIN_NEXT_ADDR_OFS = 8'h04;
  localparam logic [7:0] MAIN_CUR_CNT_OFS = 8'h08;
  localparam logic [7:0] MAIN_NEXT_CNT_OFS = 8'h0C;
  localparam logic [7:0] LIST_CUR_ADDR_OFS = 8'h10;
  localparam logic [7:0] LIST_NEXT_ADDR_OFS = 8'h14;
  localparam logic [7:0] LIST_CUR_CNT_OFS = 8'h18;
  localparam logic [7:0] LIST_NEXT_CNT_OFS = 8'h1C;

  // Field layout of the count-and-control words
  localparam int CNT_W = 16;
  localparam int CNT_MSB = 15;
  localparam int CTL_IEN_BIT = 28;
  localparam int CTL_GO_BIT = 29;
  localparam int CTL_DIR_BIT = 30;

  // Descriptor layout: 64 bits, address word high, control and count low
  localparam int DESC_W = 64;
  localparam int DESC_ADDR_LSB = 32;
  localparam int DESC_MARK_BIT = 16;
  localparam logic [15:0] DESC_BYTES = 16'h0008;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
  localparam logic [15:0] DESC_ALIGN_MASK = 16'hFFF8;

  // Buffered page entry: {dir, ien, mark, addr, count}
  localparam int ENTRY_W = 51;

  // Reset values
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] ZERO_CNT = 16'h0000;

  // Descriptor fetch sequencer
  typedef enum logic [1:0] {
    SGD_FETCH_IDLE = 2'b00,
    SGD_FETCH_REQ = 2'b01,
    SGD_FETCH_PUSH = 2'b10
  } sgd_fetch_type;

  // Main page mover handshake
  typedef enum logic [1:0] {
    SGD_PAGE_IDLE = 2'b00,
    SGD_PAGE_OFFER = 2'b01,
    SGD_PAGE_RUN = 2'b10
  } sgd_page_type;

endpackage

// File: sgd_channel.sv
`timescale 1ns/1ps

module sgd_channel #(
  parameter int DEPTH = 2
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic REG_WR_EN_IN,
  input wire logic REG_RD_EN_IN,
  input wire logic [sgd_pkg::REG_ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  output logic MEM_RD_REQ_OUT,
  output logic [31:0] MEM_RD_ADDR_OUT,
  input wire logic MEM_RD_VALID_IN,
  input wire logic [sgd_pkg::DESC_W-1:0] MEM_RD_DATA_IN,
  output logic PAGE_VALID_OUT,
  input wire logic PAGE_READY_IN,
  output logic [31:0] PAGE_ADDR_OUT,
  output logic [15:0] PAGE_COUNT_OUT,
  output logic PAGE_DIR_OUT,
  input wire logic PAGE_DONE_IN,
  output logic MAIN_IRQ_OUT
);
  import sgd_pkg::*;

  // Reset release synchroniser
  logic rst_meta_b_r;
  logic rst_b_r;

  // Two flops so reset leaves every register on the same edge
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_meta_b_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_meta_b_r <= 1'b1;
      rst_b_r <= rst_meta_b_r;
    end
  end

  // Two-entry page buffer between fetch and main mover
  logic [ENTRY_W-1:0] buf_mem_r [DEPTH];
  logic [ENTRY_W-1:0] buf_mem_nxt [DEPTH];
  logic buf_wr_ptr_r, buf_wr_ptr_nxt;
  logic buf_rd_ptr_r, buf_rd_ptr_nxt;
  logic [1:0] buf_cnt_r, buf_cnt_nxt;
  logic buf_in_valid; // Fetch offers an entry
  logic buf_in_ready; // Buffer has room
  logic buf_out_valid; // Buffer holds an entry
  logic buf_out_ready; // Mover takes the head entry
  logic [ENTRY_W-1:0] buf_head; // Oldest entry
  logic [ENTRY_W-1:0] fetch_entry_r, fetch_entry_nxt;

  assign buf_in_ready = (buf_cnt_r != 2'(DEPTH));
  assign buf_out_valid = (buf_cnt_r != 2'b00);
  assign buf_head = buf_mem_r[buf_rd_ptr_r];

  // Buffer next state; order is kept by one write and one read pointer
  always_comb begin
    buf_wr_ptr_nxt = buf_wr_ptr_r;
    buf_rd_ptr_nxt = buf_rd_ptr_r;
    buf_cnt_nxt = buf_cnt_r;
    for (int i = 0; i < DEPTH; i++) begin
      buf_mem_nxt[i] = buf_mem_r[i];
    end
    if (buf_in_valid && buf_in_ready) begin
      buf_mem_nxt[buf_wr_ptr_r] = fetch_entry_r;
      buf_wr_ptr_nxt = ~buf_wr_ptr_r;
    end
    if (buf_out_valid && buf_out_ready) begin
      buf_rd_ptr_nxt = ~buf_rd_ptr_r;
    end
    // Net occupancy change
    if ((buf_in_valid && buf_in_ready) && !(buf_out_valid && buf_out_ready)) begin
      buf_cnt_nxt = buf_cnt_r + 2'b01;
    end else if (!(buf_in_valid && buf_in_ready) && (buf_out_valid && buf_out_ready)) begin
      buf_cnt_nxt = buf_cnt_r - 2'b01;
    end
  end

  // Buffer entries, one flop group per entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_buf
    always_ff @(posedge CLK_IN or negedge rst_b_r) begin
      if (!rst_b_r) begin
        buf_mem_r[g] <= '0;
      end else begin
        buf_mem_r[g] <= buf_mem_nxt[g];
      end
    end
  end

  // Buffer pointers
  always_ff @(posedge CLK_IN or negedge rst_b_r) begin
    if (!rst_b_r) begin
      buf_wr_ptr_r <= 1'b0;
      buf_rd_ptr_r <= 1'b0;
      buf_cnt_r <= 2'b00;
    end else begin
      buf_wr_ptr_r <= buf_wr_ptr_nxt;
      buf_rd_ptr_r <= buf_rd_ptr_nxt;
      buf_cnt_r <= buf_cnt_nxt;
    end
  end

  // List registers and fetch sequencer state
  sgd_fetch_type fetch_state_r, fetch_state_nxt;
  logic [31:0] list_next_addr_r, list_next_addr_nxt; // Host-written next list address
  logic [15:0] list_next_cnt_r, list_next_cnt_nxt; // Next list length in bytes
  logic list_ien_next_r, list_ien_next_nxt; // Interrupt enable for next list
  logic list_dir_next_r, list_dir_next_nxt; // Direction for next list
  logic list_go_r, list_go_nxt; // Next list waits to start
  logic [31:0] list_cur_addr_r, list_cur_addr_nxt; // Address of next descriptor
  logic [15:0] list_cur_cnt_r, list_cur_cnt_nxt; // Bytes of list left
  logic list_ien_r, list_ien_nxt; // Interrupt enable of running list
  logic list_dir_r, list_dir_nxt; // Direction of running list
  logic mem_req_r, mem_req_nxt;
  logic [31:0] mem_addr_r, mem_addr_nxt;
  logic host_wr_next_cnt; // Host write hits next count and control

  assign host_wr_next_cnt = REG_WR_EN_IN && (REG_ADDR_IN == LIST_NEXT_CNT_OFS);
  assign buf_in_valid = (fetch_state_r == SGD_FETCH_PUSH);

  // Fetch next state
  always_comb begin
    fetch_state_nxt = fetch_state_r;
    list_next_addr_nxt = list_next_addr_r;
    list_next_cnt_nxt = list_next_cnt_r;
    list_ien_next_nxt = list_ien_next_r;
    list_dir_next_nxt = list_dir_next_r;
    list_go_nxt = list_go_r;
    list_cur_addr_nxt = list_cur_addr_r;
    list_cur_cnt_nxt = list_cur_cnt_r;
    list_ien_nxt = list_ien_r;
    list_dir_nxt = list_dir_r;
    mem_req_nxt = mem_req_r;
    mem_addr_nxt = mem_addr_r;
    fetch_entry_nxt = fetch_entry_r;
    unique case (fetch_state_r)
      SGD_FETCH_IDLE: begin
        if (list_cur_cnt_r != ZERO_CNT) begin
          // Ask host memory for the next descriptor
          mem_req_nxt = 1'b1;
          mem_addr_nxt = list_cur_addr_r;
          fetch_state_nxt = SGD_FETCH_REQ;
        end else if (list_go_r) begin
          // Current list done, take over the queued one
          list_cur_addr_nxt = list_next_addr_r;
          list_cur_cnt_nxt = list_next_cnt_r;
          list_ien_nxt = list_ien_next_r;
          list_dir_nxt = list_dir_next_r;
          list_go_nxt = 1'b0;
        end
      end
      SGD_FETCH_REQ: begin
        if (MEM_RD_VALID_IN) begin
          mem_req_nxt = 1'b0;
          // Split the descriptor into address, mark and count
          fetch_entry_nxt = {list_dir_r, list_ien_r,
            MEM_RD_DATA_IN[DESC_MARK_BIT],
            MEM_RD_DATA_IN[DESC_ADDR_LSB +: 32],
            MEM_RD_DATA_IN[CNT_MSB:0]};
          list_cur_addr_nxt = list_cur_addr_r + DESC_STRIDE;
          list_cur_cnt_nxt = list_cur_cnt_r - DESC_BYTES;
          fetch_state_nxt = SGD_FETCH_PUSH;
        end
      end
      SGD_FETCH_PUSH: begin
        // Stall here while the buffer is full
        if (buf_in_ready) begin
          fetch_state_nxt = SGD_FETCH_IDLE;
        end
      end
      default: begin
        fetch_state_nxt = SGD_FETCH_IDLE;
      end
    endcase
    // Host writes land after the hardware update, so a start is never lost
    if (REG_WR_EN_IN && (REG_ADDR_IN == LIST_NEXT_ADDR_OFS)) begin
      list_next_addr_nxt = REG_WDATA_IN;
    end
    if (host_wr_next_cnt) begin
      list_next_cnt_nxt = REG_WDATA_IN[CNT_MSB:0] & DESC_ALIGN_MASK;
      list_ien_next_nxt = REG_WDATA_IN[CTL_IEN_BIT];
      list_dir_next_nxt = REG_WDATA_IN[CTL_DIR_BIT];
      list_go_nxt = REG_WDATA_IN[CTL_GO_BIT];
    end
  end

  // Fetch registers
  always_ff @(posedge CLK_IN or negedge rst_b_r) begin
    if (!rst_b_r) begin
      fetch_state_r <= SGD_FETCH_IDLE;
      list_next_addr_r <= ZERO_WORD;
      list_next_cnt_r <= ZERO_CNT;
      list_ien_next_r <= 1'b0;
      list_dir_next_r <= 1'b0;
      list_go_r <= 1'b0;
      list_cur_addr_r <= ZERO_WORD;
      list_cur_cnt_r <= ZERO_CNT;
      list_ien_r <= 1'b0;
      list_dir_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_addr_r <= ZERO_WORD;
      fetch_entry_r <= '0;
    end else begin
      fetch_state_r <= fetch_state_nxt;
      list_next_addr_r <= list_next_addr_nxt;
      list_next_cnt_r <= list_next_cnt_nxt;
      list_ien_next_r <= list_ien_next_nxt;
      list_dir_next_r <= list_dir_next_nxt;
      list_go_r <= list_go_nxt;
      list_cur_addr_r <= list_cur_addr_nxt;
      list_cur_cnt_r <= list_cur_cnt_nxt;
      list_ien_r <= list_ien_nxt;
      list_dir_r <= list_dir_nxt;
      mem_req_r <= mem_req_nxt;
      mem_addr_r <= mem_addr_nxt;
      fetch_entry_r <= fetch_entry_nxt;
    end
  end

  // Main DMA registers, loaded only from the buffer
  sgd_page_type page_state_r, page_state_nxt;
  logic [31:0] main_addr_r, main_addr_nxt; // Page start address
  logic [15:0] main_cnt_r, main_cnt_nxt; // Page byte count
  logic main_mark_r, main_mark_nxt; // Page flagged for interrupt
  logic main_ien_r, main_ien_nxt; // List interrupt enable
  logic main_dir_r, main_dir_nxt; // Scatter when set
  logic irq_r, irq_nxt;
  logic page_valid_r, page_valid_nxt; // Offer flag kept in its own flop so the pin is clean

  assign buf_out_ready = (page_state_r == SGD_PAGE_IDLE);

  // Page mover next state
  always_comb begin
    page_state_nxt = page_state_r;
    main_addr_nxt = main_addr_r;
    main_cnt_nxt = main_cnt_r;
    main_mark_nxt = main_mark_r;
    main_ien_nxt = main_ien_r;
    main_dir_nxt = main_dir_r;
    irq_nxt = 1'b0;
    unique case (page_state_r)
      SGD_PAGE_IDLE: begin
        if (buf_out_valid) begin
          // Copy the head descriptor into the main registers
          {main_dir_nxt, main_ien_nxt, main_mark_nxt, main_addr_nxt, main_cnt_nxt} =
            buf_head;
          page_state_nxt = SGD_PAGE_OFFER;
        end
      end
      SGD_PAGE_OFFER: begin
        if (PAGE_READY_IN) begin
          page_state_nxt = SGD_PAGE_RUN;
        end
      end
      SGD_PAGE_RUN: begin
        if (PAGE_DONE_IN) begin
          irq_nxt = main_mark_r && main_ien_r;
          page_state_nxt = SGD_PAGE_IDLE;
        end
      end
      default: begin
        page_state_nxt = SGD_PAGE_IDLE;
      end
    endcase
    // Offer flag follows the state it enters, so it stands exactly while offering
    page_valid_nxt = (page_state_nxt == SGD_PAGE_OFFER);
  end

  // Page mover registers
  always_ff @(posedge CLK_IN or negedge rst_b_r) begin
    if (!rst_b_r) begin
      page_state_r <= SGD_PAGE_IDLE;
      main_addr_r <= ZERO_WORD;
      main_cnt_r <= ZERO_CNT;
      main_mark_r <= 1'b0;
      main_ien_r <= 1'b0;
      main_dir_r <= 1'b0;
      irq_r <= 1'b0;
      page_valid_r <= 1'b0;
    end else begin
      page_state_r <= page_state_nxt;
      main_addr_r <= main_addr_nxt;
      main_cnt_r <= main_cnt_nxt;
      main_mark_r <= main_mark_nxt;
      main_ien_r <= main_ien_nxt;
      main_dir_r <= main_dir_nxt;
      irq_r <= irq_nxt;
      page_valid_r <= page_valid_nxt;
    end
  end

  // Register read port
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] head_addr; // Main next address view
  logic [31:0] head_cnt; // Main next count view

  assign head_addr = buf_out_valid ? buf_head[CNT_W +: 32] : ZERO_WORD;
  assign head_cnt = buf_out_valid ?
    {15'h0000, buf_head[CNT_W + 32], buf_head[CNT_MSB:0]} : ZERO_WORD;

  // Read decode; main registers only answer reads, writes to them are dropped
  always_comb begin
    rvalid_nxt = REG_RD_EN_IN;
    rdata_nxt = rdata_r;
    if (REG_RD_EN_IN) begin
      unique case (REG_ADDR_IN)
        MAIN_CUR_ADDR_OFS: rdata_nxt = main_addr_r;
        MAIN_NEXT_ADDR_OFS: rdata_nxt = head_addr;
        MAIN_CUR_CNT_OFS: rdata_nxt = {15'h0000, main_mark_r, main_cnt_r};
        MAIN_NEXT_CNT_OFS: rdata_nxt = head_cnt;
        LIST_CUR_ADDR_OFS: rdata_nxt = list_cur_addr_r;
        LIST_NEXT_ADDR_OFS: rdata_nxt = list_next_addr_r;
        LIST_CUR_CNT_OFS: begin
          rdata_nxt = {1'b0, list_dir_r, 1'b0, list_ien_r, 12'h000, list_cur_cnt_r};
        end
        LIST_NEXT_CNT_OFS: begin
          rdata_nxt = {1'b0, list_dir_next_r, list_go_r, list_ien_next_r, 12'h000,
            list_next_cnt_r};
        end
        default: rdata_nxt = ZERO_WORD; // Unmapped reads give zero
      endcase
    end
  end

  // Read data registers
  always_ff @(posedge CLK_IN or negedge rst_b_r) begin
    if (!rst_b_r) begin
      rdata_r <= ZERO_WORD;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Outputs, all straight from flops
  assign REG_RDATA_OUT = rdata_r;
  assign REG_RVALID_OUT = rvalid_r;
  assign MEM_RD_REQ_OUT = mem_req_r;
  assign MEM_RD_ADDR_OUT = mem_addr_r;
  assign PAGE_VALID_OUT = page_valid_r;
  assign PAGE_ADDR_OUT = main_addr_r;
  assign PAGE_COUNT_OUT = main_cnt_r;
  assign PAGE_DIR_OUT = main_dir_r;
  assign MAIN_IRQ_OUT = irq_r;

endmodule // sgd_channel

// File: sgd_channel_props.sv
`timescale 1ns/1ps
// Protocol checker for the channel's fetch, page and register ports
module sgd_channel_props (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic REG_RD_EN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic REG_RVALID_OUT,
  input wire logic MEM_RD_REQ_OUT,
  input wire logic [31:0] MEM_RD_ADDR_OUT,
  input wire logic MEM_RD_VALID_IN,
  input wire logic PAGE_VALID_OUT,
  input wire logic PAGE_READY_IN,
  input wire logic [31:0] PAGE_ADDR_OUT,
  input wire logic [15:0] PAGE_COUNT_OUT,
  input wire logic PAGE_DIR_OUT,
  input wire logic PAGE_DONE_IN,
  input wire logic MAIN_IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Fetch request and its address hold until answered
  a_req_hold: assert property (MEM_RD_REQ_OUT && !MEM_RD_VALID_IN |=>
    MEM_RD_REQ_OUT && $stable(MEM_RD_ADDR_OUT)) else $error("fetch request not held");
  a_req_release: assert property (MEM_RD_REQ_OUT && MEM_RD_VALID_IN |=>
    !MEM_RD_REQ_OUT) else $error("fetch request not released");
  // Offered page is frozen until the mover takes it
  a_offer_hold: assert property (PAGE_VALID_OUT && !PAGE_READY_IN |=> PAGE_VALID_OUT &&
    $stable(PAGE_ADDR_OUT) && $stable(PAGE_COUNT_OUT) && $stable(PAGE_DIR_OUT))
    else $error("page offer changed");
  a_offer_release: assert property (PAGE_VALID_OUT && PAGE_READY_IN |=>
    !PAGE_VALID_OUT) else $error("page offer not released");
  a_page_gap: assert property (PAGE_DONE_IN |=> !PAGE_VALID_OUT)
    else $error("next page offered too early");
  // Interrupt is a single pulse caused by a page finishing
  a_irq_cause: assert property (MAIN_IRQ_OUT |-> $past(PAGE_DONE_IN))
    else $error("interrupt without page done");
  a_irq_pulse: assert property (MAIN_IRQ_OUT |=> !MAIN_IRQ_OUT)
    else $error("interrupt longer than one cycle");
  // Register reads answer one cycle later
  a_read_answer: assert property (REG_RD_EN_IN |=> REG_RVALID_OUT)
    else $error("read not answered");
  a_read_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_EN_IN))
    else $error("read valid without read");
  a_unmapped_zero: assert property (REG_RD_EN_IN && REG_ADDR_IN > 8'h1C |=>
    REG_RDATA_OUT == 32'h0) else $error("unmapped read not zero");
  c_fetch: cover property (MEM_RD_REQ_OUT && MEM_RD_VALID_IN);
  c_accept: cover property (PAGE_VALID_OUT && PAGE_READY_IN);
  c_irq: cover property (MAIN_IRQ_OUT);
endmodule // sgd_channel_props

bind sgd_channel sgd_channel_props u_props (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .REG_RD_EN_IN(REG_RD_EN_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .MEM_RD_REQ_OUT(MEM_RD_REQ_OUT), .MEM_RD_ADDR_OUT(MEM_RD_ADDR_OUT),
  .MEM_RD_VALID_IN(MEM_RD_VALID_IN), .PAGE_VALID_OUT(PAGE_VALID_OUT),
  .PAGE_READY_IN(PAGE_READY_IN), .PAGE_ADDR_OUT(PAGE_ADDR_OUT),
  .PAGE_COUNT_OUT(PAGE_COUNT_OUT), .PAGE_DIR_OUT(PAGE_DIR_OUT),
  .PAGE_DONE_IN(PAGE_DONE_IN), .MAIN_IRQ_OUT(MAIN_IRQ_OUT));

// File: sgd_host_model.sv
`timescale 1ns/1ps
// Host memory holding descriptor lists, plus the main page mover
module sgd_host_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  input wire logic page_valid_in,
  input wire logic slow_in,
  output logic valid_out,
  output logic [63:0] data_out,
  output logic ready_out,
  output logic done_out
);
  int mem_wait; // Cycles before the next descriptor beat
  int pg_wait; // Cycles before the mover acts
  logic busy; // Mover owns a page
  // Answers fetches and moves pages, slowly when asked
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      valid_out <= 1'h0;
      data_out <= 64'h0;
      ready_out <= 1'h0;
      done_out <= 1'h0;
      mem_wait <= 0;
      pg_wait <= 0;
      busy <= 1'h0;
    end else begin
      valid_out <= 1'h0;
      ready_out <= 1'h0;
      done_out <= 1'h0;
      data_out <= ~data_out; // Released data lines do not hold
      if (req_in && !valid_out) begin
        if (mem_wait == 0) begin
          valid_out <= 1'h1;
          // One eight-byte beat: page address high, noise, mark, count low
          data_out <= {addr_in ^ 32'hA5A5_0000, 15'h5555, addr_in[3] ^ addr_in[4],
                       addr_in[15:0] ^ 16'h0F0F};
          mem_wait <= slow_in ? int'($urandom % 4) : 0;
        end else begin
          mem_wait <= mem_wait - 1;
        end
      end
      if (pg_wait != 0) begin
        pg_wait <= pg_wait - 1;
      end else if (busy) begin
        done_out <= 1'h1; // Page finished only after it was taken
        busy <= 1'h0;
        pg_wait <= slow_in ? int'($urandom % 6) : 0;
      end else if (page_valid_in && !ready_out) begin
        ready_out <= 1'h1;
        busy <= 1'h1;
        pg_wait <= slow_in ? int'($urandom % 6) : 0;
      end
    end
  end
endmodule // sgd_host_model

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import sgd_pkg::*;
  logic clk = 1'h0; // Board clock
  logic rst_b = 1'h0; // Board reset, active low
  logic wr_en = 1'h0, rd_en = 1'h0, slow = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, maddr, paddr, d, last_pa, list_end, last_cnt;
  logic [63:0] mdata;
  logic [15:0] pcount;
  logic rvalid, mreq, mvalid, pvalid, pready, pdir, pdone, irq;
  int n_fail = 0, checks = 0, done_cnt = 0, irq_cnt = 0, exp_irq = 0, n_pages = 0;
  logic [31:0] fetch_q[$]; // Expected fetch addresses
  logic [48:0] page_q[$]; // Expected {dir, addr, count}

  always #5 clk = ~clk;

  sgd_channel #(.DEPTH(2)) u_sgd_channel (
    .CLK_IN(clk), .RST_B_IN(rst_b), .REG_WR_EN_IN(wr_en), .REG_RD_EN_IN(rd_en),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .MEM_RD_REQ_OUT(mreq), .MEM_RD_ADDR_OUT(maddr), .MEM_RD_VALID_IN(mvalid),
    .MEM_RD_DATA_IN(mdata), .PAGE_VALID_OUT(pvalid), .PAGE_READY_IN(pready),
    .PAGE_ADDR_OUT(paddr), .PAGE_COUNT_OUT(pcount), .PAGE_DIR_OUT(pdir),
    .PAGE_DONE_IN(pdone), .MAIN_IRQ_OUT(irq));

  sgd_host_model u_sgd_host_model (
    .clk_in(clk), .rst_b_in(rst_b), .req_in(mreq), .addr_in(maddr),
    .page_valid_in(pvalid), .slow_in(slow), .valid_out(mvalid), .data_out(mdata),
    .ready_out(pready), .done_out(pdone));

  // Compare and count
  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Register write: one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    wr_en = 1'h1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr_en = 1'h0;
  endtask

  // Register read: data arrives with the valid pulse
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk);
    rd_en = 1'h1;
    addr = a;
    @(negedge clk);
    rd_en = 1'h0;
    chk(rvalid, 1'h1);
    v = rdata;
  endtask

  // Queue expectations for a list, then hand it to the channel
  task automatic load_list(input logic [31:0] base, input int n, input logic dir, ien,
                           input logic [2:0] junk);
    logic [31:0] a;
    for (int i = 0; i < n; i++) begin
      a = base + 32'(i * 8);
      fetch_q.push_back(a);
      page_q.push_back({dir, a ^ 32'hA5A5_0000, a[15:0] ^ 16'h0F0F});
      exp_irq += int'(ien & (a[3] ^ a[4]));
      last_pa = a ^ 32'hA5A5_0000;
      last_cnt = {15'h0000, a[3] ^ a[4], a[15:0] ^ 16'h0F0F};
    end
    list_end = base + 32'(n * 8);
    n_pages += n;
    wr(8'h14, base);
    wr(8'h1C, {1'h0, dir, 1'h1, ien, 12'h000, 16'(n * 8) | {13'h0, junk}});
  endtask

  // Watch fetches, page hand-overs, completions and interrupts
  always @(posedge clk) begin
    if (mreq && mvalid) begin
      chk(maddr, fetch_q.size() > 0 ? fetch_q.pop_front() : 32'hFFFF_FFFF);
    end
    if (pvalid && pready) begin
      chk({pdir, paddr, pcount}, page_q.size() > 0 ? page_q.pop_front() : '1);
    end
    if (pdone) done_cnt++;
    if (irq) irq_cnt++;
  end

  initial begin
    logic dir, ien;
    void'($urandom(44070));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1'h1;
    repeat (3) @(posedge clk);
    rd(8'h14, d);
    chk(d, 32'h0);
    rd(8'h1C, d);
    chk(d, 32'h0);
    rd(8'hFC, d);
    chk(d, 32'h0);
    wr(8'h00, 32'h1234_5678);
    rd(8'h00, d);
    chk(d, 32'h0);
    for (int r = 0; r < 5; r++) begin
      dir = 1'($urandom % 2);
      ien = (r == 0) ? 1'h1 : 1'($urandom % 2);
      slow = r[0];
      load_list($urandom & 32'hFFFF_FFF8, (r == 0) ? 1 : 1 + $urandom % 6, dir, ien,
                3'(r));
      d = 32'hFFFF_FFFF;
      for (int k = 0; k < 300 && d[29]; k++) rd(8'h1C, d);
      if (d[29]) begin
        n_fail++;
        break;
      end
      chk({d[30], d[28], d[2:0]}, {dir, ien, 3'h0});
      load_list($urandom & 32'hFFFF_FFF8, 1 + $urandom % 4, ~dir, ien, 3'h0);
      for (int k = 0; k < 20000 && done_cnt != n_pages; k++) @(posedge clk);
      if (done_cnt != n_pages) begin
        n_fail++;
        break;
      end
      repeat (3) @(posedge clk);
      chk(irq_cnt, exp_irq);
      wr(8'h00, 32'hFFFF_FFFF);
      rd(8'h00, d);
      chk(d, last_pa);
      rd(8'h08, d);
      chk(d, last_cnt);
      rd(8'h0C, d);
      chk(d, 32'h0);
      rd(8'h10, d);
      chk(d, list_end);
      rd(8'h18, d);
      chk(d, {1'h0, ~dir, 1'h0, ien, 28'h0000000});
    end
    report_and_stop();
  end
endmodule // tb
